/* File: hw/i2c_nv_defines.svh */
// constants of the two-wire nonvolatile slave: addresses, field widths, timing
// assumes inclusion by bare name from every design file that needs a figure
`ifndef I2C_NV_DEFINES_SVH
`define I2C_NV_DEFINES_SVH

`define SLV_ADDR_HI 4'ha
`define BYTE_LAST_BIT 4'h7
`define ACK_SLOT 4'h8
`define MEM_AW 8
`define MEM_DEPTH 256
`define MEM_RESET_VAL 8'h00
`define RES_COUNT 3
`define RES_POS_W 6
`define RES_ADDR_BASE 8'hf8
`define RES_MAX 8'h3f
`define NV_PROGRAM_TIME_NS 10000000
`define CLK_FREQ_MHZ 200
`define NS_PER_US 1000

`endif

/* File: hw/i2c_nv_pkg.sv */
// types shared by the two-wire slave core and its nonvolatile page store
// assumes nothing beyond the defines header
package i2c_nv_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_wr,
    st_rd,
    st_ignore
  } link_state_e;

  // one page program request: page index, per-byte write mask, two data bytes
  typedef struct packed {
    logic [6:0] page;
    logic [1:0] mask;
    logic [1:0][7:0] data;
  } page_req_s;

endpackage : i2c_nv_pkg

/* File: hw/pin_sync.sv */
// two flip-flop synchroniser for pins and toggles entering the i_clk domain
// assumes the input is a level that stays put for several i_clk periods
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= i_d;
      q_r <= meta_r;
    end
  end

  assign o_q = q_r;

endmodule : pin_sync

/* File: hw/nv_page_store.sv */
// byte array with two-byte page programming and the resistor setting outputs
// assumes one program request at a time, offered only while o_busy is low
`timescale 1ns/1ps
`include "i2c_nv_defines.svh"
module nv_page_store #(
  parameter int PROG_CYCLES = 2000000,
  parameter int DEPTH = `MEM_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_go,
  input wire i2c_nv_pkg::page_req_s i_req,
  input wire logic [`MEM_AW-1:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  output logic o_busy,
  output logic [`RES_COUNT*`RES_POS_W-1:0] o_res_pos,
  output logic [`RES_COUNT-1:0] o_res_hiz
);

  i2c_nv_pkg::byte_t mem [DEPTH];
  i2c_nv_pkg::page_req_s req_r;
  logic busy_r;
  logic [31:0] cnt_r;
  logic [7:0] rd_data_r;
  logic [`RES_POS_W-1:0] pos_r [`RES_COUNT];
  logic [`RES_COUNT-1:0] hiz_r;

  wire done = busy_r && (cnt_r == 32'(PROG_CYCLES - 1));
  wire accept = i_go && !busy_r;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_r <= 1'b0;
      cnt_r <= '0;
      req_r <= '0;
    end else if (accept) begin
      busy_r <= 1'b1;
      cnt_r <= '0;
      req_r <= i_req;
    end else if (done) begin
      busy_r <= 1'b0;
    end else if (busy_r) begin
      cnt_r <= cnt_r + 32'h1;
    end
  end

  // whole page, masked bytes
  // contents change only at the end of the programming time, so a read during it sees old data
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int k = 0; k < DEPTH; k++) mem[k] <= `MEM_RESET_VAL;
    end else if (done) begin
      for (int b = 0; b < 2; b++) begin
        if (req_r.mask[b]) mem[{req_r.page, 1'(b)}] <= req_r.data[b];
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_data_r <= '0;
    end else begin
      rd_data_r <= mem[i_rd_addr];
    end
  end

  for (genvar i = 0; i < `RES_COUNT; i++) begin : g_res
    wire [7:0] setting = mem[8'(`RES_ADDR_BASE + i)];
    always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        pos_r[i] <= '0;
        hiz_r[i] <= 1'b0;
      end else begin
        pos_r[i] <= setting[`RES_POS_W-1:0];
        hiz_r[i] <= setting > `RES_MAX;
      end
    end
    assign o_res_pos[i*`RES_POS_W +: `RES_POS_W] = pos_r[i];
  end

  assign o_res_hiz = hiz_r;
  assign o_rd_data = rd_data_r;
  assign o_busy = busy_r;

endmodule : nv_page_store

/* File: hw/i2c_slave_nv.sv */
// two-wire serial slave with address counter, two-byte page writes and sequential reads
// assumes an open-drain bus resolved outside; i_scl is the master's clock and may stop
// Behaviour
// - sda falling while scl high starts transfer
// - sda rising while scl high stops transfer
// - bus idle only with both lines high
// - repeated start handled exactly like start
// - data sampled on rising scl edge
// - device drives bits after scl falls
// - eight bits msb first, ninth bit ack
// - first byte: seven-bit address plus direction
// - three address bits follow strap pins
// - direction zero writes, one reads
// - wrong address: no ack, ignore until start
// - second write byte loads address counter
// - data stored consecutively in two-byte page
// - write counter wraps within current page
// - no address ack while page programs
// - programming keeps unwritten page bytes
// - reads use the current address counter
// - reads continue while master acknowledges
// - setting above 3Fh makes resistor high-z
`timescale 1ns/1ps
`include "i2c_nv_defines.svh"
module i2c_slave_nv #(
  parameter int NV_PROG_CYCLES = int'((64'(`NV_PROGRAM_TIME_NS) * 64'(`CLK_FREQ_MHZ)
                                       + 64'(`NS_PER_US - 1)) / 64'(`NS_PER_US))
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda_i,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic i_addr_strap_bit0,
  input wire logic i_addr_strap_bit1,
  input wire logic i_addr_strap_bit2,
  output logic o_bus_idle,
  output logic o_nv_busy,
  output logic [`RES_COUNT*`RES_POS_W-1:0] o_res_pos,
  output logic [`RES_COUNT-1:0] o_res_hiz
);

  // link domain: the master's clock itself samples the data line
  logic lk_bit_r;
  logic lk_tgl_r;

  always_ff @(posedge i_scl or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lk_bit_r <= 1'b0;
      lk_tgl_r <= 1'b0;
    end else begin
      lk_bit_r <= i_sda_i;
      lk_tgl_r <= ~lk_tgl_r;
    end
  end

  // crossings into i_clk: the toggle announces a bit, the bit itself is then long stable
  logic tgl_s;
  logic tgl_p_r;
  logic [1:0] pins_s;
  logic [2:0] strap_s;
  logic scl_p_r;
  logic sda_p_r;

  pin_sync #(.W(1)) u_tgl_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d(lk_tgl_r),
    .o_q(tgl_s)
  );

  pin_sync #(.W(2)) u_pin_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d({i_scl, i_sda_i}),
    .o_q(pins_s)
  );

  pin_sync #(.W(3)) u_strap_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_d({i_addr_strap_bit2, i_addr_strap_bit1, i_addr_strap_bit0}),
    .o_q(strap_s)
  );

  wire scl_s = pins_s[1];
  wire sda_s = pins_s[0];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      // match the synchroniser's reset level so no false edge follows reset
      tgl_p_r <= 1'b0;
      scl_p_r <= 1'b0;
      sda_p_r <= 1'b0;
    end else begin
      tgl_p_r <= tgl_s;
      scl_p_r <= scl_s;
      sda_p_r <= sda_s;
    end
  end

  wire start_det = scl_s && scl_p_r && sda_p_r && !sda_s;
  wire stop_det = scl_s && scl_p_r && !sda_p_r && sda_s;
  wire scl_fall = scl_p_r && !scl_s;
  wire ev_rise = tgl_s ^ tgl_p_r;

  // core state
  i2c_nv_pkg::link_state_e state_r, state_nxt;
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [7:0] sr_r, sr_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic [7:0] addr_cnt_r, addr_cnt_nxt;
  logic got_mem_r, got_mem_nxt;
  logic ack_r, ack_nxt;
  logic rw_r, rw_nxt;
  logic [1:0][7:0] pbuf_r, pbuf_nxt;
  logic [1:0] pmask_r, pmask_nxt;
  logic sda_oe_r, sda_oe_nxt;
  logic prog_go_r;
  logic idle_r;
  logic nv_busy;
  logic [7:0] rd_data;
  i2c_nv_pkg::page_req_s req;

  wire active = (state_r != i2c_nv_pkg::st_idle) && (state_r != i2c_nv_pkg::st_ignore);
  wire [7:0] rx_byte = {sr_r[6:0], lk_bit_r};
  wire bit_ev = active && ev_rise && (bit_cnt_r < `ACK_SLOT);
  wire ack_ev = active && ev_rise && (bit_cnt_r == `ACK_SLOT);
  wire byte_ev = bit_ev && (bit_cnt_r == `BYTE_LAST_BIT);
  // a program cycle pending or running blocks the address
  wire busy_all = nv_busy || prog_go_r;
  wire addr_ok = (rx_byte[7:1] == {`SLV_ADDR_HI, strap_s}) && !busy_all;
  wire in_addr = state_r == i2c_nv_pkg::st_addr;
  wire in_wr = state_r == i2c_nv_pkg::st_wr;
  wire in_rd = state_r == i2c_nv_pkg::st_rd;
  wire load_tx = ack_ev && ((in_addr && ack_r && rw_r) || (in_rd && !lk_bit_r));
  wire wr_data_ev = byte_ev && in_wr && got_mem_r;
  wire recv_ack = (bit_cnt_r == `ACK_SLOT) && ack_r && (in_addr || in_wr);
  wire tx_bit = tx_r[~bit_cnt_r[2:0]];
  wire prog_go_nxt = stop_det && in_wr && (pmask_r != 2'h0);

  always_comb begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    sr_nxt = sr_r;
    tx_nxt = tx_r;
    addr_cnt_nxt = addr_cnt_r;
    got_mem_nxt = got_mem_r;
    ack_nxt = ack_r;
    rw_nxt = rw_r;
    pbuf_nxt = pbuf_r;
    pmask_nxt = pmask_r;
    if (start_det) begin
      state_nxt = i2c_nv_pkg::st_addr;
      bit_cnt_nxt = 4'h0;
      got_mem_nxt = 1'b0;
      ack_nxt = 1'b0;
      pmask_nxt = 2'h0;
    end else if (stop_det) begin
      state_nxt = i2c_nv_pkg::st_idle;
      bit_cnt_nxt = 4'h0;
      ack_nxt = 1'b0;
      pmask_nxt = 2'h0;
    end else begin
      if (bit_ev) begin
        sr_nxt = rx_byte;
        bit_cnt_nxt = bit_cnt_r + 4'h1;
      end
      if (byte_ev && in_addr) begin
        ack_nxt = addr_ok;
        rw_nxt = rx_byte[0];
        if (!addr_ok) state_nxt = i2c_nv_pkg::st_ignore;
      end
      if (byte_ev && in_wr) begin
        ack_nxt = 1'b1;
        if (!got_mem_r) begin
          addr_cnt_nxt = rx_byte;
          got_mem_nxt = 1'b1;
        end else begin
          pbuf_nxt[addr_cnt_r[0]] = rx_byte;
          pmask_nxt[addr_cnt_r[0]] = 1'b1;
          addr_cnt_nxt = {addr_cnt_r[7:1], ~addr_cnt_r[0]};
        end
      end
      if (ack_ev) begin
        bit_cnt_nxt = 4'h0;
        if (in_addr) state_nxt = rw_r ? i2c_nv_pkg::st_rd : i2c_nv_pkg::st_wr;
        if (in_rd && lk_bit_r) state_nxt = i2c_nv_pkg::st_ignore;
      end
      if (load_tx) begin
        tx_nxt = rd_data;
        addr_cnt_nxt = addr_cnt_r + 8'h1;
      end
    end
  end

  always_comb begin
    sda_oe_nxt = sda_oe_r;
    if (start_det || stop_det) begin
      sda_oe_nxt = 1'b0;
    end else if (scl_fall) begin
      if (recv_ack) begin
        sda_oe_nxt = 1'b1;
      end else if (in_rd && (bit_cnt_r < `ACK_SLOT)) begin
        sda_oe_nxt = ~tx_bit;
      end else begin
        sda_oe_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= i2c_nv_pkg::st_idle;
      bit_cnt_r <= 4'h0;
      sr_r <= 8'h00;
      tx_r <= 8'h00;
      addr_cnt_r <= 8'h00;
      got_mem_r <= 1'b0;
      ack_r <= 1'b0;
      rw_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      sr_r <= sr_nxt;
      tx_r <= tx_nxt;
      addr_cnt_r <= addr_cnt_nxt;
      got_mem_r <= got_mem_nxt;
      ack_r <= ack_nxt;
      rw_r <= rw_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pbuf_r <= '0;
      pmask_r <= 2'h0;
      sda_oe_r <= 1'b0;
      prog_go_r <= 1'b0;
      idle_r <= 1'b0;
    end else begin
      pbuf_r <= pbuf_nxt;
      pmask_r <= pmask_nxt;
      sda_oe_r <= sda_oe_nxt;
      prog_go_r <= prog_go_nxt;
      idle_r <= (state_nxt == i2c_nv_pkg::st_idle) && scl_s && sda_s;
    end
  end

  // the page snapshot is taken from registers, which the stop leaves untouched for one cycle
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req <= '0;
    end else if (prog_go_nxt) begin
      req <= '{page: addr_cnt_r[7:1], mask: pmask_r, data: pbuf_r};
    end
  end

  nv_page_store #(.PROG_CYCLES(NV_PROG_CYCLES)) u_store (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_go(prog_go_r),
    .i_req(req),
    .i_rd_addr(addr_cnt_r),
    .o_rd_data(rd_data),
    .o_busy(nv_busy),
    .o_res_pos(o_res_pos),
    .o_res_hiz(o_res_hiz)
  );

  assign o_sda_o = 1'b0;
  assign o_sda_oe = sda_oe_r;
  assign o_bus_idle = idle_r;
  assign o_nv_busy = busy_all;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  AST_START_ARMS: assert property (
    start_det |=> (state_r == i2c_nv_pkg::st_addr) && (bit_cnt_r == 4'h0) && !sda_oe_r)
    else $error("start did not arm address phase");

  AST_STOP_IDLES: assert property (
    stop_det |=> (state_r == i2c_nv_pkg::st_idle) && !sda_oe_r)
    else $error("stop did not return to idle");

  AST_IDLE_LINES: assert property (
    o_bus_idle |-> $past(scl_s) && $past(sda_s))
    else $error("idle flagged with a line low");

  AST_RESTART_NO_PROG: assert property (
    (start_det && in_wr) |=> !prog_go_r && (pmask_r == 2'h0))
    else $error("restart started a program cycle");

  AST_OE_AFTER_FALL: assert property (
    $changed(sda_oe_r) |-> $past(scl_fall || start_det || stop_det))
    else $error("sda drive changed outside a low phase");

  AST_BYTE_TO_ACK: assert property (
    byte_ev && !in_addr |=> bit_cnt_r == `ACK_SLOT)
    else $error("byte did not reach the ack slot");

  AST_MISMATCH_IGNORE: assert property (
    (byte_ev && in_addr && !addr_ok && !start_det) |=> state_r == i2c_nv_pkg::st_ignore
      ##1 !sda_oe_r)
    else $error("wrong address was not ignored");

  AST_BUSY_NO_ACK: assert property (
    (byte_ev && in_addr && busy_all && !start_det) |=> !ack_r)
    else $error("address acknowledged while programming");

  AST_PAGE_WRAP: assert property (
    (wr_data_ev && !start_det) |=> addr_cnt_r[7:1] == $past(addr_cnt_r[7:1])
      && addr_cnt_r[0] != $past(addr_cnt_r[0]))
    else $error("write counter left its page");

  AST_READ_ADVANCE: assert property (
    (load_tx && !start_det && !stop_det) |=> addr_cnt_r == $past(addr_cnt_r) + 8'h1)
    else $error("read did not advance the counter");

  AST_STOP_PROGRAMS: assert property (
    (stop_det && in_wr && (pmask_r != 2'h0)) |=> prog_go_r ##1 o_nv_busy)
    else $error("page write stop did not program");

endmodule : i2c_slave_nv

/* File: dv/i2c_master_model.sv */
// behavioural two-wire bus master: drives scl, pulls the data line low, reports each byte
// assumes a free-running link clock and a pull-up on the resolved data line
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic i_link_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe,
  output logic [8:0] o_res,
  output logic o_res_stb
);
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
    o_res = 9'h000;
    o_res_stb = 1'b0;
  end

  task automatic post(input logic [8:0] r);
    o_res = r;
    o_res_stb = 1'b1;
    #1 o_res_stb = 1'b0;
  endtask : post

  // change while low
  // data moves mid-low so the slave's 3-4 cycle answer has settled before the rise
  task automatic bit_io(input logic b, output logic s);
    @(negedge i_link_clk);
    o_scl = 1'b0;
    #20 o_sda_oe = ~b;
    @(posedge i_link_clk);
    s = i_sda;
    o_scl = 1'b1;
  endtask : bit_io

  task automatic start();
    @(negedge i_link_clk);
    o_scl = 1'b0;
    #20 o_sda_oe = 1'b0;
    @(posedge i_link_clk);
    o_scl = 1'b1;
    #20 o_sda_oe = 1'b1;
  endtask : start

  task automatic stop();
    @(negedge i_link_clk);
    o_scl = 1'b0;
    #20 o_sda_oe = 1'b1;
    @(posedge i_link_clk);
    o_scl = 1'b1;
    #20 o_sda_oe = 1'b0;
  endtask : stop

  task automatic wr_byte(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    post({8'h00, s});
  endtask : wr_byte

  task automatic rd_byte(input logic ack);
    logic [7:0] d;
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~ack, s);
    post({1'b1, d});
  endtask : rd_byte
endmodule : i2c_master_model

/* File: dv/testbench.sv */
// self-checking bench for the two-wire nonvolatile slave
// assumes the master model in its own file and a pull-up on the data line
`timescale 1ns/1ps
`include "i2c_nv_defines.svh"
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
  localparam int PROG = 400;
  logic clk, rst_n, lclk, scl, m_oe, oe_d, sda_d, sda, s0, s1, s2, idle, busy, res_stb;
  logic [`RES_COUNT*`RES_POS_W-1:0] rpos;
  logic [`RES_COUNT-1:0] rhiz;
  logic [8:0] res, e;
  logic [8:0] expq[$];
  logic [6:0] sa;
  logic [7:0] pg, d0, d1, d2;
  int errors = 0;
  int cmp_count = 0;

  // open drain with pull-up: released line reads high
  assign sda = (m_oe | (oe_d & ~sda_d)) ? 1'b0 : 1'b1;

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever #40 lclk = ~lclk;
  end

  i2c_slave_nv #(.NV_PROG_CYCLES(PROG)) i_dut (.i_clk(clk), .i_rst_n(rst_n), .i_scl(scl),
    .i_sda_i(sda), .o_sda_o(sda_d), .o_sda_oe(oe_d), .i_addr_strap_bit0(s0),
    .i_addr_strap_bit1(s1), .i_addr_strap_bit2(s2), .o_bus_idle(idle), .o_nv_busy(busy),
    .o_res_pos(rpos), .o_res_hiz(rhiz));
  i2c_master_model i_master (.i_link_clk(lclk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe),
    .o_res(res), .o_res_stb(res_stb));

  task automatic close_out();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  // the oldest note is the one the reported byte must match
  always @(posedge res_stb) begin
    if (expq.size() == 0) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, res, 9'h000);
    end else begin
      e = expq.pop_front();
      `CHK(res, e)
    end
  end

  task automatic wr(input logic [7:0] d, input logic nack);
    expq.push_back({8'h00, nack});
    i_master.wr_byte(d);
  endtask : wr

  task automatic rd(input logic [7:0] d, input logic ack);
    expq.push_back({1'b1, d});
    i_master.rd_byte(ack);
  endtask : rd

  // bounded wait; programming must end within its cycle count plus margin
  task automatic wait_ready();
    int i;
    // busy only shows a few cycles after the stop reaches the pins
    repeat (4) @(negedge clk);
    for (i = 0; i < PROG + 100; i++) begin
      @(negedge clk);
      if (busy === 1'b0) break;
    end
    if (i >= PROG + 100) begin
      errors++;
      close_out();
    end
    // resistor outputs follow the array one registered cycle later
    repeat (2) @(negedge clk);
  endtask : wait_ready

  task automatic set_ptr(input logic [7:0] a);
    i_master.start();
    wr({sa, 1'b0}, 1'b0);
    wr(a, 1'b0);
    i_master.start();
    wr({sa, 1'b1}, 1'b0);
  endtask : set_ptr

  task automatic page_wr(input logic [7:0] a, input logic [7:0] x, input logic [7:0] y);
    i_master.start();
    wr({sa, 1'b0}, 1'b0);
    wr(a, 1'b0);
    wr(x, 1'b0);
    wr(y, 1'b0);
    i_master.stop();
    wait_ready();
  endtask : page_wr

  initial begin
    rst_n = 1'b0;
    {s2, s1, s0} = 3'h0;
    d0 = 8'($urandom(32'h93ed068a));
    repeat (16) @(negedge clk);
    {s2, s1, s0} = 3'($urandom);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    sa = {4'ha, s2, s1, s0};
    `CHK(idle, 1'b1)
    `CHK(rhiz, 3'h0)
    `CHK(sda_d, 1'b0)
    i_master.start();
    repeat (3) @(negedge clk);
    `CHK(idle, 1'b0)
    wr({sa ^ 7'h02, 1'b0}, 1'b1);
    wr(8'h10, 1'b1);
    i_master.stop();
    pg = 8'($urandom_range(0, 246)) & 8'hfe;
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    i_master.start();
    wr({sa, 1'b0}, 1'b0);
    wr(pg, 1'b0);
    wr(d0, 1'b0);
    wr(d1, 1'b0);
    wr(d2, 1'b0);
    i_master.stop();
    repeat (4) @(negedge clk);
    `CHK(busy, 1'b1)
    i_master.start();
    wr({sa, 1'b1}, 1'b1);
    i_master.stop();
    wait_ready();
    set_ptr(pg);
    rd(d2, 1'b1);
    rd(d1, 1'b1);
    rd(8'h00, 1'b0);
    i_master.stop();
    repeat (4) @(negedge clk);
    `CHK(busy, 1'b0)
    `CHK(idle, 1'b1)
    i_master.start();
    wr({sa, 1'b1}, 1'b0);
    rd(8'h00, 1'b0);
    i_master.stop();
    i_master.start();
    wr({sa, 1'b0}, 1'b0);
    wr(pg + 8'h01, 1'b0);
    wr(d0, 1'b0);
    i_master.stop();
    wait_ready();
    set_ptr(pg);
    rd(d2, 1'b1);
    rd(d0, 1'b0);
    i_master.stop();
    d0 = 8'h40 + 8'($urandom_range(0, 191));
    d1 = 8'($urandom) & 8'h3f;
    page_wr(`RES_ADDR_BASE, d0, d1);
    `CHK(rhiz, 3'h1)
    `CHK(rpos[11:6], d1[5:0])
    `CHK(rpos[5:0], d0[5:0])
    page_wr(`RES_ADDR_BASE + 8'h02, 8'h3f, 8'h00);
    `CHK(rhiz, 3'h1)
    `CHK(rpos[17:12], 6'h3f)
    repeat (20) @(negedge clk);
    if (expq.size() != 0) begin
      errors++;
    end
    close_out();
  end
endmodule : testbench
